/* rlfc_char_match.sv */
`timescale 1ns/10ps
`default_nettype none

module rlfc_char_match (
	input  wire logic [7:0] rxChar,
	input  wire logic [7:0] refChar,
	input  wire logic [7:0] mask,
	input  wire logic [1:0] charLen,
	output logic            hit
);

	logic [2:0] topBit;
	logic [7:0] bitOk;

	// charLen 0..3 selects 5..8 significant bits from the lsb
	assign topBit = 3'h4 + {1'b0, charLen};

	for (genvar i = 0; i < 8; i++)
	begin : g_bit
		assign bitOk[i] = (3'(i) > topBit) || mask[i] || (rxChar[i] == refChar[i]);
	end

	assign hit = &bitOk;

endmodule : rlfc_char_match

`default_nettype wire

/* rlfc_len_check.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rlfc_params.svh"

module rlfc_len_check (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        enable,
	input  wire logic        byteVld,
	input  wire logic        frameStart,
	input  wire logic [10:0] limitField,
	output logic             exceedNow,
	output logic             overLimit
);

	rlfc_pkg::rlfc_len_s s_q;
	rlfc_pkg::rlfc_len_s s_d;
	logic [16:0]         limit;
	logic [16:0]         nextCount;

	assign limit = {12'({1'b0, limitField} + 12'h1), 5'h0};
	assign nextCount = frameStart ? 17'h1 : s_q.count + 17'h1;
	assign exceedNow = enable && byteVld && (frameStart || !s_q.over) && (nextCount > limit);
	assign overLimit = s_q.over;

	always_comb
	begin
		s_d = s_q;
		// counting stops once over, the frame is then treated as aborted
		if (byteVld && (frameStart || !s_q.over))
		begin
			s_d.count = nextCount;
			s_d.over = exceedNow;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	AST_LEN_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(s_q.over) |-> (s_q.count == limit + 17'h1))
		else $error("length overrun flagged at wrong count");

	AST_COUNT_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
		(byteVld && frameStart) |=> (s_q.count == 17'h1))
		else $error("frame byte count did not restart");

	AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (rst)
		(byteVld && !frameStart && !s_q.over) |=> (s_q.count == $past(s_q.count) + 17'h1))
		else $error("frame byte not counted");

endmodule : rlfc_len_check

`default_nettype wire

/* rlfc_params.svh */
`ifndef RLFC_PARAMS_SVH
`define RLFC_PARAMS_SVH

// --------------------------------------------------------------------
// register indices, byte address is four times the index
// --------------------------------------------------------------------
`define RLFC_ADDR_W        10
`define RLFC_CH_STRIDE     8'h50
`define RLFC_IDX_CFG       8'h3c
`define RLFC_IDX_STAT      8'h3d
`define RLFC_IDX_CLR       8'h3e
`define RLFC_IDX_EN        8'h3f
`define RLFC_IDX_LIM_LOW   8'h48
`define RLFC_IDX_LIM_HIGH  8'h49
`define RLFC_IDX_RESUME    8'h4a
`define RLFC_IDX_PAUSE     8'h4b
`define RLFC_IDX_RES_MASK  8'h4c
`define RLFC_IDX_PAU_MASK  8'h4d
`define RLFC_IDX_END_CHAR  8'h4e

// --------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------
`define RLFC_CFG_PAR_EN    4
`define RLFC_CFG_STORE_DIS 5
`define RLFC_CFG_INBAND    6
`define RLFC_CFG_END_DET   7
`define RLFC_LIM_RCE       7
`define RLFC_IRQ_LEN       0
`define RLFC_IRQ_MSGEND    1
`define RLFC_IRQ_RESUME    2
`define RLFC_IRQ_PAUSE     3
`define RLFC_IRQ_ENDCHAR   4
`define RLFC_ABORT_BIT     5
`define RLFC_LEN_SHIFT     5
`define RLFC_REG_RESET     8'h00
`define RLFC_RESP_OKAY     2'h0
`define RLFC_RESP_SLVERR   2'h2

`endif

/* rlfc_pkg.sv */
package rlfc_pkg;

	localparam int NCH = 2;

	typedef enum logic [1:0] {
		RLFC_MODE_FRAMED   = 2'b00,
		RLFC_MODE_ASYNC    = 2'b01,
		RLFC_MODE_BYTESYNC = 2'b10,
		RLFC_MODE_SPARE    = 2'b11
	} rlfc_mode_e;

	typedef struct packed {
		logic       vld;
		logic       frameStart;
		logic       frameEnd;
		logic       framingOk;
		logic       parityOk;
		logic [7:0] data;
	} rlfc_rx_s;

	typedef struct packed {
		logic       fifoWr;
		logic       isStatus;
		logic [7:0] data;
		logic       abortReq;
		logic       endCharHit;
		logic       txPaused;
	} rlfc_chout_s;

	typedef struct packed {
		logic [7:0] resumeChar;
		logic [7:0] pauseChar;
		logic [7:0] resumeMask;
		logic [7:0] pauseMask;
		logic [7:0] endChar;
		logic [7:0] limitLow;
		logic       length_check_enable;
		logic [2:0] limitHigh;
		logic [7:0] cfg;
		logic [4:0] irqEn;
		logic [4:0] irqStat;
		logic       msgEndPend;
	} rlfc_chreg_s;

	typedef struct packed {
		logic       awRdy;
		logic       wRdy;
		logic       awHeld;
		logic       wHeld;
		logic [9:0] wAddr;
		logic [7:0] wData;
		logic       wLane;
		logic       bValid;
		logic [1:0] bResp;
		logic       arRdy;
		logic       rValid;
		logic [7:0] rData;
		logic [1:0] rResp;
	} rlfc_axi_s;

	typedef struct packed {
		rlfc_axi_s                  axi;
		rlfc_chreg_s [NCH-1:0] ch;
		rlfc_chout_s [NCH-1:0] out;
		logic                       irq;
	} rlfc_state_s;

	typedef struct packed {
		logic [16:0] count;
		logic        over;
	} rlfc_len_s;

endpackage : rlfc_pkg

/* rlfc_remote_station.sv */
`timescale 1ns/10ps
`default_nettype none

module rlfc_remote_station (
	input  wire logic                                   clk_sys,
	output var rlfc_pkg::rlfc_rx_s [rlfc_pkg::NCH-1:0] rxIn
);
	initial rxIn = '0;

	// ----------------------------------------------------------------
	// one byte per call, launched right after a rising edge
	// ----------------------------------------------------------------
	// flags are {frameStart, frameEnd, framingOk, parityOk}
	task automatic send(input int ch, input logic [7:0] d, input logic [3:0] flags);
		@(posedge clk_sys);
		rxIn[ch] <= {1'b1, flags, d};
	endtask : send

	// a released line shows the inverse of the last byte so stale data never matches
	task automatic idle(input int ch);
		@(posedge clk_sys);
		rxIn[ch] <= {1'b0, 4'h0, ~rxIn[ch].data};
	endtask : idle
endmodule : rlfc_remote_station
`default_nettype wire

/* rlfc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rlfc_params.svh"

module rlfc_top (
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst,
	input  wire logic [9:0]                            s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	input  wire logic [31:0]                           s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	output logic [1:0]                                 s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	input  wire logic [9:0]                            s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	output logic [31:0]                                s_axi_rdata,
	output logic [1:0]                                 s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	input  wire rlfc_pkg::rlfc_rx_s [rlfc_pkg::NCH-1:0] rxIn,
	output var rlfc_pkg::rlfc_chout_s [rlfc_pkg::NCH-1:0] chOut,
	output logic                                       irq
);

	rlfc_pkg::rlfc_state_s     s_q;
	rlfc_pkg::rlfc_state_s     s_d;
	logic [rlfc_pkg::NCH-1:0]  isFramed;
	logic [rlfc_pkg::NCH-1:0]  isAsync;
	logic [rlfc_pkg::NCH-1:0]  lenEn;
	logic [rlfc_pkg::NCH-1:0]  exceedNow;
	logic [rlfc_pkg::NCH-1:0]  overLimit;
	logic [rlfc_pkg::NCH-1:0]  resMatch;
	logic [rlfc_pkg::NCH-1:0]  pauMatch;
	logic [rlfc_pkg::NCH-1:0]  flowOk;
	logic [rlfc_pkg::NCH-1:0]  resHit;
	logic [rlfc_pkg::NCH-1:0]  pauHit;
	logic [rlfc_pkg::NCH-1:0]  endHit;

	// --------------------------------------------------------------------
	// outputs straight from the state register
	// --------------------------------------------------------------------
	assign s_axi_awready = s_q.axi.awRdy;
	assign s_axi_wready  = s_q.axi.wRdy;
	assign s_axi_bvalid  = s_q.axi.bValid;
	assign s_axi_bresp   = s_q.axi.bResp;
	assign s_axi_arready = s_q.axi.arRdy;
	assign s_axi_rvalid  = s_q.axi.rValid;
	assign s_axi_rresp   = s_q.axi.rResp;
	assign s_axi_rdata   = {24'h0, s_q.axi.rData};
	assign chOut         = s_q.out;
	assign irq           = s_q.irq;

	// --------------------------------------------------------------------
	// per channel matching and length checking
	// --------------------------------------------------------------------
	for (genvar c = 0; c < rlfc_pkg::NCH; c++)
	begin : g_ch
		assign isFramed[c] = rlfc_pkg::rlfc_mode_e'(s_q.ch[c].cfg[1:0]) == rlfc_pkg::RLFC_MODE_FRAMED;
		assign isAsync[c]  = rlfc_pkg::rlfc_mode_e'(s_q.ch[c].cfg[1:0]) == rlfc_pkg::RLFC_MODE_ASYNC;
		assign lenEn[c]    = s_q.ch[c].length_check_enable && isFramed[c];
		assign flowOk[c]   = isAsync[c] && rxIn[c].vld && rxIn[c].framingOk
			&& (!s_q.ch[c].cfg[`RLFC_CFG_PAR_EN] || rxIn[c].parityOk);
		assign resHit[c]   = flowOk[c] && resMatch[c];
		assign pauHit[c]   = flowOk[c] && pauMatch[c];
		// end character only has meaning in the character modes
		assign endHit[c]   = s_q.ch[c].cfg[`RLFC_CFG_END_DET] && !isFramed[c] && rxIn[c].vld
			&& (rxIn[c].data == s_q.ch[c].endChar);

		rlfc_char_match u_res (
			.rxChar  (rxIn[c].data),
			.refChar (s_q.ch[c].resumeChar),
			.mask    (s_q.ch[c].resumeMask),
			.charLen (s_q.ch[c].cfg[3:2]),
			.hit     (resMatch[c])
		);

		rlfc_char_match u_pau (
			.rxChar  (rxIn[c].data),
			.refChar (s_q.ch[c].pauseChar),
			.mask    (s_q.ch[c].pauseMask),
			.charLen (s_q.ch[c].cfg[3:2]),
			.hit     (pauMatch[c])
		);

		rlfc_len_check u_len (
			.clk_sys    (clk_sys),
			.rst        (rst),
			.enable     (lenEn[c]),
			.byteVld    (rxIn[c].vld && isFramed[c]),
			.frameStart (rxIn[c].frameStart),
			.limitField ({s_q.ch[c].limitHigh, s_q.ch[c].limitLow}),
			.exceedNow  (exceedNow[c]),
			.overLimit  (overLimit[c])
		);

		AST_LEN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
			!lenEn[c] |=> !chOut[c].abortReq)
			else $error("length abort raised while check disabled");

		AST_ABORT_MARK: assert property (@(posedge clk_sys) disable iff (rst)
			(lenEn[c] && rxIn[c].vld && rxIn[c].frameEnd
			&& (exceedNow[c] || (overLimit[c] && !rxIn[c].frameStart)))
			|=> (chOut[c].fifoWr && chOut[c].isStatus && chOut[c].data[`RLFC_ABORT_BIT]))
			else $error("abort bit missing in status byte of overlong frame");

		AST_LENGTH_EXCEEDED_IRQ_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
			(lenEn[c] && rxIn[c].vld && rxIn[c].frameEnd && exceedNow[c])
			|=> (s_q.ch[c].irqStat[`RLFC_IRQ_LEN] && s_q.ch[c].msgEndPend)
			##1 s_q.ch[c].irqStat[`RLFC_IRQ_MSGEND])
			else $error("length event not ahead of message end");

		AST_RESUME_EQ: assert property (@(posedge clk_sys) disable iff (rst)
			resHit[c] |-> (((rxIn[c].data ^ s_q.ch[c].resumeChar) & ~s_q.ch[c].resumeMask
			& (8'hff >> (2'h3 - s_q.ch[c].cfg[3:2]))) == 8'h00))
			else $error("resume recognised on mismatching character");

		AST_PAUSE_EQ: assert property (@(posedge clk_sys) disable iff (rst)
			pauHit[c] |-> (((rxIn[c].data ^ s_q.ch[c].pauseChar) & ~s_q.ch[c].pauseMask
			& (8'hff >> (2'h3 - s_q.ch[c].cfg[3:2]))) == 8'h00))
			else $error("pause recognised on mismatching character");

		AST_STORE_DIS: assert property (@(posedge clk_sys) disable iff (rst)
			((resHit[c] || pauHit[c]) && s_q.ch[c].cfg[`RLFC_CFG_STORE_DIS]) |=> !chOut[c].fifoWr)
			else $error("flow character stored although storing disabled");

		AST_TX_PAUSE: assert property (@(posedge clk_sys) disable iff (rst)
			(pauHit[c] && s_q.ch[c].cfg[`RLFC_CFG_INBAND])
			|=> (chOut[c].txPaused && s_q.ch[c].irqStat[`RLFC_IRQ_PAUSE]))
			else $error("pause character did not pause transmitter");

		AST_TX_RESUME: assert property (@(posedge clk_sys) disable iff (rst)
			(resHit[c] && !pauHit[c] && s_q.ch[c].cfg[`RLFC_CFG_INBAND])
			|=> (!chOut[c].txPaused && s_q.ch[c].irqStat[`RLFC_IRQ_RESUME]))
			else $error("resume character did not resume transmitter");

		AST_END_OFF: assert property (@(posedge clk_sys) disable iff (rst)
			!s_q.ch[c].cfg[`RLFC_CFG_END_DET] |=> !chOut[c].endCharHit)
			else $error("end character flagged while detection off");

		AST_LEN_MODE: assert property (@(posedge clk_sys) disable iff (rst)
			!isFramed[c] |=> (!chOut[c].abortReq && !chOut[c].isStatus))
			else $error("length check acted outside framed mode");

		AST_FLOW_FRAMING: assert property (@(posedge clk_sys) disable iff (rst)
			(rxIn[c].vld && (!rxIn[c].framingOk
			|| (s_q.ch[c].cfg[`RLFC_CFG_PAR_EN] && !rxIn[c].parityOk)))
			|=> $stable(chOut[c].txPaused))
			else $error("badly framed character changed transmitter state");

		AST_MASK_EXACT: assert property (@(posedge clk_sys) disable iff (rst)
			(resHit[c] && (s_q.ch[c].resumeMask == 8'h00) && (s_q.ch[c].cfg[3:2] == 2'h3))
			|-> (rxIn[c].data == s_q.ch[c].resumeChar))
			else $error("unmasked resume bits did not match exactly");

		AST_MSG_END: assert property (@(posedge clk_sys) disable iff (rst)
			chOut[c].isStatus |=> s_q.ch[c].irqStat[`RLFC_IRQ_MSGEND])
			else $error("message end not raised after status byte");

		AST_STORE_ON: assert property (@(posedge clk_sys) disable iff (rst)
			((resHit[c] || pauHit[c]) && !s_q.ch[c].cfg[`RLFC_CFG_STORE_DIS]) |=> chOut[c].fifoWr)
			else $error("flow character dropped although storing enabled");
	end

	// --------------------------------------------------------------------
	// next state: bus slave, registers, channel events
	// --------------------------------------------------------------------
	always_comb
	begin
		logic [7:0]                       idx;
		logic [7:0]                       off;
		logic [7:0]                       wd;
		logic [rlfc_pkg::NCH-1:0][4:0]    clrMask;
		logic [4:0]                       setBits;
		logic                             overNow;
		logic                             irqAny;
		idx     = 8'h00;
		off     = 8'h00;
		wd      = s_q.axi.wData;
		clrMask = '0;
		setBits = 5'h00;
		overNow = 1'b0;
		irqAny  = 1'b0;
		s_d     = s_q;

		// write address and data may arrive in either order
		if (s_axi_awvalid && s_q.axi.awRdy)
		begin
			s_d.axi.awHeld = 1'b1;
			s_d.axi.wAddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.axi.wRdy)
		begin
			s_d.axi.wHeld = 1'b1;
			s_d.axi.wData = s_axi_wdata[7:0];
			s_d.axi.wLane = s_axi_wstrb[0];
		end
		if (s_q.axi.bValid && s_axi_bready)
			s_d.axi.bValid = 1'b0;
		if (s_q.axi.awHeld && s_q.axi.wHeld && !s_q.axi.bValid)
		begin
			s_d.axi.awHeld = 1'b0;
			s_d.axi.wHeld  = 1'b0;
			s_d.axi.bValid = 1'b1;
			s_d.axi.bResp  = `RLFC_RESP_SLVERR;
			idx = s_q.axi.wAddr[9:2];
			for (int c = 0; c < rlfc_pkg::NCH; c++)
			begin
				off = idx - 8'(c * `RLFC_CH_STRIDE);
				case (off)
					`RLFC_IDX_CFG:      if (s_q.axi.wLane) s_d.ch[c].cfg = wd;
					`RLFC_IDX_EN:       if (s_q.axi.wLane) s_d.ch[c].irqEn = wd[4:0];
					`RLFC_IDX_CLR:      if (s_q.axi.wLane) clrMask[c] = wd[4:0];
					`RLFC_IDX_STAT:     ;
					`RLFC_IDX_LIM_LOW:  if (s_q.axi.wLane) s_d.ch[c].limitLow = wd;
					`RLFC_IDX_LIM_HIGH:
					if (s_q.axi.wLane)
					begin
						s_d.ch[c].length_check_enable       = wd[`RLFC_LIM_RCE];
						s_d.ch[c].limitHigh = wd[2:0];
					end
					`RLFC_IDX_RESUME:   if (s_q.axi.wLane) s_d.ch[c].resumeChar = wd;
					`RLFC_IDX_PAUSE:    if (s_q.axi.wLane) s_d.ch[c].pauseChar = wd;
					`RLFC_IDX_RES_MASK: if (s_q.axi.wLane) s_d.ch[c].resumeMask = wd;
					`RLFC_IDX_PAU_MASK: if (s_q.axi.wLane) s_d.ch[c].pauseMask = wd;
					`RLFC_IDX_END_CHAR: if (s_q.axi.wLane) s_d.ch[c].endChar = wd;
					default:            ;
				endcase
				case (off)
					`RLFC_IDX_CFG, `RLFC_IDX_EN, `RLFC_IDX_CLR, `RLFC_IDX_STAT,
					`RLFC_IDX_LIM_LOW, `RLFC_IDX_LIM_HIGH, `RLFC_IDX_RESUME, `RLFC_IDX_PAUSE,
					`RLFC_IDX_RES_MASK, `RLFC_IDX_PAU_MASK, `RLFC_IDX_END_CHAR:
						s_d.axi.bResp = `RLFC_RESP_OKAY;
					default: ;
				endcase
			end
		end

		if (s_q.axi.rValid && s_axi_rready)
			s_d.axi.rValid = 1'b0;
		if (s_axi_arvalid && s_q.axi.arRdy)
		begin
			s_d.axi.rValid = 1'b1;
			s_d.axi.rResp  = `RLFC_RESP_SLVERR;
			s_d.axi.rData  = 8'h00;
			idx = s_axi_araddr[9:2];
			for (int c = 0; c < rlfc_pkg::NCH; c++)
			begin
				off = idx - 8'(c * `RLFC_CH_STRIDE);
				case (off)
					`RLFC_IDX_CFG:      s_d.axi.rData = s_q.ch[c].cfg;
					`RLFC_IDX_EN:       s_d.axi.rData = {3'h0, s_q.ch[c].irqEn};
					`RLFC_IDX_CLR:      s_d.axi.rData = 8'h00;
					`RLFC_IDX_STAT:     s_d.axi.rData = {s_q.out[c].txPaused, 2'h0, s_q.ch[c].irqStat};
					`RLFC_IDX_LIM_LOW:  s_d.axi.rData = s_q.ch[c].limitLow;
					`RLFC_IDX_LIM_HIGH: s_d.axi.rData = {s_q.ch[c].length_check_enable, 4'h0, s_q.ch[c].limitHigh};
					`RLFC_IDX_RESUME:   s_d.axi.rData = s_q.ch[c].resumeChar;
					`RLFC_IDX_PAUSE:    s_d.axi.rData = s_q.ch[c].pauseChar;
					`RLFC_IDX_RES_MASK: s_d.axi.rData = s_q.ch[c].resumeMask;
					`RLFC_IDX_PAU_MASK: s_d.axi.rData = s_q.ch[c].pauseMask;
					`RLFC_IDX_END_CHAR: s_d.axi.rData = isFramed[c] ? 8'h00 : s_q.ch[c].endChar;
					default:            ;
				endcase
				case (off)
					`RLFC_IDX_CFG, `RLFC_IDX_EN, `RLFC_IDX_CLR, `RLFC_IDX_STAT,
					`RLFC_IDX_LIM_LOW, `RLFC_IDX_LIM_HIGH, `RLFC_IDX_RESUME, `RLFC_IDX_PAUSE,
					`RLFC_IDX_RES_MASK, `RLFC_IDX_PAU_MASK, `RLFC_IDX_END_CHAR:
						s_d.axi.rResp = `RLFC_RESP_OKAY;
					default: ;
				endcase
			end
		end

		// one transfer of each kind in flight
		s_d.axi.awRdy = !s_d.axi.awHeld && !s_d.axi.bValid;
		s_d.axi.wRdy  = !s_d.axi.wHeld && !s_d.axi.bValid;
		s_d.axi.arRdy = !s_d.axi.rValid;

		for (int c = 0; c < rlfc_pkg::NCH; c++)
		begin
			overNow = lenEn[c] && (exceedNow[c] || (overLimit[c] && !rxIn[c].frameStart));
			s_d.out[c].fifoWr = rxIn[c].vld
				&& !((resHit[c] || pauHit[c]) && s_q.ch[c].cfg[`RLFC_CFG_STORE_DIS])
				&& !(overNow && !rxIn[c].frameEnd);
			s_d.out[c].isStatus = rxIn[c].vld && rxIn[c].frameEnd && isFramed[c];
			s_d.out[c].data = rxIn[c].data;
			if (s_d.out[c].isStatus && overNow)
				s_d.out[c].data[`RLFC_ABORT_BIT] = 1'b1;
			s_d.out[c].abortReq   = exceedNow[c];
			s_d.out[c].endCharHit = endHit[c];
			if (s_q.ch[c].cfg[`RLFC_CFG_INBAND])
			begin
				// a pause wins when both patterns match the same character
				if (pauHit[c])
					s_d.out[c].txPaused = 1'b1;
				else if (resHit[c])
					s_d.out[c].txPaused = 1'b0;
			end
			// message end waits a cycle so a length event on the status byte lands first
			s_d.ch[c].msgEndPend = s_d.out[c].isStatus;
			setBits = 5'h00;
			setBits[`RLFC_IRQ_LEN]     = exceedNow[c];
			setBits[`RLFC_IRQ_MSGEND]  = s_q.ch[c].msgEndPend;
			setBits[`RLFC_IRQ_RESUME]  = resHit[c];
			setBits[`RLFC_IRQ_PAUSE]   = pauHit[c];
			setBits[`RLFC_IRQ_ENDCHAR] = endHit[c];
			// a set in the clearing cycle survives
			s_d.ch[c].irqStat = (s_q.ch[c].irqStat & ~clrMask[c]) | setBits;
			irqAny = irqAny || |(s_d.ch[c].irqStat & s_d.ch[c].irqEn);
		end
		s_d.irq = irqAny;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
		irq == |((s_q.ch[0].irqStat & s_q.ch[0].irqEn) | (s_q.ch[1].irqStat & s_q.ch[1].irqEn)))
		else $error("interrupt line disagrees with enabled status");

endmodule : rlfc_top

`default_nettype wire

/* rlfc_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rlfc_params.svh"

module rlfc_top_test;
	logic                                  clk_sys = 1'b0;
	logic                                  rst     = 1'b1;
	logic [9:0]                            awAddr  = '0;
	logic                                  awValid = 1'b0;
	logic                                  awReady;
	logic [31:0]                           wData   = '0;
	logic                                  wValid  = 1'b0;
	logic                                  wReady;
	logic [1:0]                            bResp;
	logic                                  bValid;
	logic                                  bReady  = 1'b0;
	logic [9:0]                            arAddr  = '0;
	logic                                  arValid = 1'b0;
	logic                                  arReady;
	logic [31:0]                           rData;
	logic [1:0]                            rResp;
	logic                                  rValid;
	logic                                  rReady  = 1'b0;
	rlfc_pkg::rlfc_rx_s [rlfc_pkg::NCH-1:0]    rxIn;
	rlfc_pkg::rlfc_chout_s [rlfc_pkg::NCH-1:0] chOut;
	logic                                  irq;
	int                                    fail_count = 0;
	int                                    n_tests    = 0;
	integer                                seed       = 32'h1b81;
	logic [33:0]                           rdQ [$];
	logic [10:0]                           rxQ [$];
	int                                    i;
	// {cfg, resume mask, byte, parityOk, paused after, stored}
	localparam logic [26:0] FLOW [7] = '{
		{8'h4d, 8'h00, 8'h13, 3'b111}, {8'h4d, 8'h00, 8'h11, 3'b101},
		{8'h4d, 8'h00, 8'h33, 3'b101}, {8'h41, 8'h00, 8'h33, 3'b111},
		{8'h4d, 8'h20, 8'h31, 3'b101}, {8'h5d, 8'h00, 8'h13, 3'b001},
		{8'h6d, 8'h00, 8'h13, 3'b110}};

	always #10 clk_sys = ~clk_sys;

	rlfc_top dut_u (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .rxIn(rxIn), .chOut(chOut), .irq(irq));
	rlfc_remote_station peer_u (.clk_sys(clk_sys), .rxIn(rxIn));

	// ----------------------------------------------------------------
	// comparison, verdict, watchdog
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#400000;
		fail_count++;
		$display("watchdog expired");
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// bus master, aw and w offered together, each released when taken
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		@(posedge clk_sys);
		awAddr <= {idx, 2'b00};
		wData <= {24'h0, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
		end while (!bValid);
		bReady <= 1'b0;
		check("bresp", {32'h0, bResp}, {32'h0, resp});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		rdQ.push_back({resp, 24'h0, d});
		@(posedge clk_sys);
		arAddr <= {idx, 2'b00};
		arValid <= 1'b1;
		rReady <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (arReady) arValid <= 1'b0;
		end while (!rValid);
		rReady <= 1'b0;
	endtask : axi_rd

	// the output is sampled only after the wait, never at the call
	task automatic settle_check(input string what, input logic pickPaused, input logic exp);
		logic seen;
		repeat (3) @(posedge clk_sys);
		#1;
		seen = pickPaused ? chOut[0].txPaused : irq;
		check(what, {33'h0, seen}, {33'h0, exp});
	endtask : settle_check

	// n bytes on channel 0, the last one flagged as the appended status byte
	task automatic frame(input int n, input logic framed, input logic over);
		int k;
		logic [7:0] d;
		logic last;
		for (k = 1; k <= n; k++)
		begin
			d = 8'($random(seed));
			last = (k == n);
			if (last) d[5] = 1'b0;
			rxQ.push_back({1'b1, over && last, framed && last, d | {2'b0, over && last, 5'b0}});
			peer_u.send(0, d, {k == 1, last, 2'b11});
		end
		peer_u.idle(0);
	endtask : frame

	// ----------------------------------------------------------------
	// result watcher, oldest note against each observed result
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst && rValid && rReady)
			check("rdata", {rResp, rData}, rdQ.size() ? rdQ.pop_front() : '1);
		if (!rst && (chOut[0].fifoWr || chOut[0].abortReq))
			check("rx stream", {23'h0, chOut[0].fifoWr, chOut[0].abortReq, chOut[0].isStatus,
				chOut[0].data}, rxQ.size() ? {23'h0, rxQ.pop_front()} : '1);
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 8'h48; i <= 8'h4e; i++)
			axi_rd(i[7:0], 8'h00, `RLFC_RESP_OKAY);
		axi_rd(8'h4e + `RLFC_CH_STRIDE, 8'h00, `RLFC_RESP_OKAY);
		axi_rd(8'h01, 8'h00, `RLFC_RESP_SLVERR);
		axi_wr(8'h02, 8'h5a, `RLFC_RESP_SLVERR);
		$display("test reset and map done");
		// limit field 0 gives 32 bytes, status byte included
		axi_wr(`RLFC_IDX_LIM_HIGH, 8'h80, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_EN, 8'h03, `RLFC_RESP_OKAY);
		frame(32, 1'b1, 1'b0);
		frame(33, 1'b1, 1'b1);
		settle_check("irq", 1'b0, 1'b1);
		axi_rd(`RLFC_IDX_STAT, 8'h03, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_CLR, 8'h1f, `RLFC_RESP_OKAY);
		settle_check("irq", 1'b0, 1'b0);
		axi_wr(`RLFC_IDX_LIM_HIGH, 8'h00, `RLFC_RESP_OKAY);
		frame(33, 1'b1, 1'b0);
		axi_wr(`RLFC_IDX_LIM_HIGH, 8'h80, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_CFG, 8'h01, `RLFC_RESP_OKAY);
		frame(33, 1'b0, 1'b0);
		$display("test length check done");
		axi_wr(`RLFC_IDX_RESUME, 8'h11, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_PAUSE, 8'h13, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_CLR, 8'h1f, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_EN, 8'h0c, `RLFC_RESP_OKAY);
		for (i = 0; i < 7; i++)
		begin
			axi_wr(`RLFC_IDX_CFG, FLOW[i][26:19], `RLFC_RESP_OKAY);
			axi_wr(`RLFC_IDX_RES_MASK, FLOW[i][18:11], `RLFC_RESP_OKAY);
			if (FLOW[i][0]) rxQ.push_back({3'b100, FLOW[i][10:3]});
			peer_u.send(0, FLOW[i][10:3], {3'b001, FLOW[i][2]});
			peer_u.idle(0);
			settle_check("txPaused", 1'b1, FLOW[i][1]);
		end
		axi_rd(`RLFC_IDX_STAT, 8'h8c, `RLFC_RESP_OKAY);
		settle_check("irq", 1'b0, 1'b1);
		axi_wr(`RLFC_IDX_EN, 8'h00, `RLFC_RESP_OKAY);
		settle_check("irq", 1'b0, 1'b0);
		axi_wr(`RLFC_IDX_CLR, 8'h0c, `RLFC_RESP_OKAY);
		axi_rd(`RLFC_IDX_STAT, 8'h80, `RLFC_RESP_OKAY);
		$display("test flow characters done");
		axi_wr(`RLFC_IDX_END_CHAR + `RLFC_CH_STRIDE, 8'h55, `RLFC_RESP_OKAY);
		axi_wr(`RLFC_IDX_CFG + `RLFC_CH_STRIDE, 8'h01, `RLFC_RESP_OKAY);
		axi_rd(`RLFC_IDX_END_CHAR + `RLFC_CH_STRIDE, 8'h55, `RLFC_RESP_OKAY);
		peer_u.send(1, 8'h55, 4'h3);
		@(posedge clk_sys);
		#1;
		check("endCharHit", {33'h0, chOut[1].endCharHit}, 34'h0);
		peer_u.idle(1);
		axi_wr(`RLFC_IDX_CFG + `RLFC_CH_STRIDE, 8'h81, `RLFC_RESP_OKAY);
		peer_u.send(1, 8'h55, 4'h3);
		@(posedge clk_sys);
		#1;
		check("endCharHit", {33'h0, chOut[1].endCharHit}, 34'h1);
		peer_u.idle(1);
		axi_wr(`RLFC_IDX_CFG + `RLFC_CH_STRIDE, 8'h80, `RLFC_RESP_OKAY);
		axi_rd(`RLFC_IDX_END_CHAR + `RLFC_CH_STRIDE, 8'h00, `RLFC_RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		check("queues", {32'h0, rdQ.size() != 0, rxQ.size() != 0}, 34'h0);
		$display("test end character done");
		tally_and_finish();
	end
endmodule : rlfc_top_test
`default_nettype wire
